// *** core/gpio_change_port.v ***
// eight-pin bidirectional port with pull-ups and change detection, AXI4-Lite slave
`timescale 1ns/1ps
// Functional notes
// [RULE1] eight pins, each latch bit and direction bit
// [RULE2] direction one puts pin driver off
// [RULE3] direction zero drives latch onto pin
// [RULE4] read returns pins; write updates latch only
// [RULE5] writes store read-modified pin levels into latch; only bit-op writes do, plain port writes store the data
// [RULE6] cleared global bit enables all pull-ups; the code enables them on input pins only
// [RULE7] output pins never get a pull-up
// [RULE8] pull-ups off after reset
// [RULE9] only upper four input pins compared
// [RULE10] mismatches ORed into change flag bit zero
// [RULE11] set change flag requests wake from halt
// [RULE12] port access refreshes the compare values
// [RULE13] persisting mismatch keeps setting the flag
// [RULE14] change during a read may be missed
// [RULE15] software should not poll during change use
// [RULE16] input level overwrites latch on modify write
// [RULE17] outside must not fight a driven pin
// [RULE18] flag stays set until software clears
// [RULE19] compare each cycle on synchronised samples

`include "gpio_change_port_defines.vh"

module gpio_change_port #(
  parameter WIDTH     = 8,
  parameter ADDR_W    = 12
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire [WIDTH-1:0]  pin_in,
  output wire [WIDTH-1:0]  pin_out,
  output wire [WIDTH-1:0]  pin_oe,
  output wire [WIDTH-1:0]  pullup_en,
  output wire              change_int_flag,
  output wire              wake_req
);

  localparam NCHG = `CHG_HI - `CHG_LO + 1;

  //////////////////////////////////////////////////////////////////////////////
  // register index decode, shared by read and write paths
  function [2:0] decode;
    input [ADDR_W-1:0] addr;
    begin
      case (addr[ADDR_W-1:2])
        `IDX_PORT_DATA:     decode = 3'h1;
        `IDX_PULLUP_CONFIG: decode = 3'h2;
        `IDX_DIRECTION:     decode = 3'h3;
        `IDX_INT_CONTROL:   decode = 3'h4;
        `IDX_BIT_OP:        decode = 3'h5;
        default:            decode = 3'h0;
      endcase
    end
  endfunction

  localparam SEL_NONE  = 3'h0;
  localparam SEL_PORT  = 3'h1;
  localparam SEL_PULL  = 3'h2;
  localparam SEL_DIR   = 3'h3;
  localparam SEL_INT   = 3'h4;
  localparam SEL_BITOP = 3'h5;

  // slave error for unmapped offsets, shared by both answer channels
  function [1:0] resp_for;
    input [2:0] sel;
    begin
      if (sel == SEL_NONE)
        resp_for = `RESP_SLVERR;
      else
        resp_for = `RESP_OKAY;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // state
  reg [WIDTH-1:0]  latch_r;
  reg [WIDTH-1:0]  latch_nxt;
  reg [WIDTH-1:0]  dir_r;
  reg [WIDTH-1:0]  dir_nxt;
  reg [WIDTH-1:0]  pull_cfg_r;
  reg [WIDTH-1:0]  pull_cfg_nxt;
  reg              flag_r;
  reg              flag_nxt;
  reg [NCHG-1:0]   old_r;
  reg [NCHG-1:0]   old_nxt;
  // pin samples
  reg [WIDTH-1:0]  sync1_r;
  reg [WIDTH-1:0]  sync2_r;
  reg [31:0]       rd_word_nxt;

  // bus holding registers
  reg              aw_full_r;
  reg [ADDR_W-1:0] aw_addr_r;
  reg              w_full_r;
  reg [31:0]       w_data_r;
  reg [3:0]        w_strb_r;

  //////////////////////////////////////////////////////////////////////////////
  // pin drive and pull-ups
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : pin_g
      // driver on only while the direction bit is zero
      assign pin_oe[g]    = ~dir_r[g];                          // RULE2
      assign pin_out[g]   = latch_r[g] & ~dir_r[g];             // RULE3
      assign pullup_en[g] = ~pull_cfg_r[`PULLUP_DIS_N_BIT]      // RULE6
                            & dir_r[g];                         // RULE7
    end
  endgenerate

  // two-stage synchroniser; only the second stage is looked at
  always @(posedge aclk) begin
    sync1_r <= pin_in;
    sync2_r <= sync1_r;
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus handshakes
  wire aw_hs   = s_axi_awvalid & s_axi_awready;
  wire w_hs    = s_axi_wvalid & s_axi_wready;
  wire ar_hs   = s_axi_arvalid & s_axi_arready;
  wire wr_go   = aw_full_r & w_full_r & ~s_axi_bvalid;
  wire [2:0] wsel = decode(aw_addr_r);
  wire [2:0] rsel = decode(s_axi_araddr);
  // a write with strobe zero is answered but changes nothing
  wire wr_commit = wr_go & w_strb_r[0];

  // one write in flight: readies drop while a word is held or answered
  assign s_axi_awready = ~aw_full_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_full_r & ~s_axi_bvalid;
  // one read in flight: the next address waits for the data handshake
  assign s_axi_arready = ~s_axi_rvalid;

  wire port_wr = wr_commit & ((wsel == SEL_PORT) | (wsel == SEL_BITOP));
  wire port_rd = ar_hs & (rsel == SEL_PORT);

  //////////////////////////////////////////////////////////////////////////////
  // change detection
  wire [NCHG-1:0] mismatch;
  genvar c;
  generate
    for (c = 0; c < NCHG; c = c + 1) begin : chg_g
      // an output pin is left out of the comparison
      assign mismatch[c] = (sync2_r[`CHG_LO + c] ^ old_r[c])      // RULE19
                           & dir_r[`CHG_LO + c];                  // RULE9
    end
  endgenerate
  wire any_mismatch = |mismatch;                                  // RULE10

  assign change_int_flag = flag_r;
  // halt wake-up follows the flag directly
  assign wake_req        = flag_r;                                // RULE11

  //////////////////////////////////////////////////////////////////////////////
  // register next values
  // bit op: pins read, clear mask applied, then set mask
  wire [WIDTH-1:0] rmw_value = (sync2_r & ~w_data_r[`BITOP_CLR_LO +: WIDTH]) // RULE5
                               | w_data_r[`BITOP_SET_LO +: WIDTH];          // RULE16

  always @* begin
    latch_nxt    = latch_r;
    dir_nxt      = dir_r;
    pull_cfg_nxt = pull_cfg_r;
    if (wr_commit) begin
      case (wsel)
        // plain write: latch only, pins untouched
        SEL_PORT:  latch_nxt = w_data_r[WIDTH-1:0];               // RULE4
        // input levels overwrite their latch bits
        SEL_BITOP: latch_nxt = rmw_value;                         // RULE5 RULE16
        SEL_PULL:  pull_cfg_nxt = w_data_r[WIDTH-1:0];
        SEL_DIR:   dir_nxt = w_data_r[WIDTH-1:0];                 // RULE1
        default:   latch_nxt = latch_r;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // compare reference and change flag next values
  always @* begin
    old_nxt  = old_r;
    flag_nxt = flag_r;
    // writing zero to the flag bit clears it; writing one does nothing
    if (wr_commit && (wsel == SEL_INT)) begin
      if (!w_data_r[`CHANGE_FLAG_BIT])
        flag_nxt = 1'b0;                                          // RULE18
    end
    // a sample taken in the access cycle is the new reference, but it is also
    // compared with the old one in that cycle, so an edge landing there is still flagged
    if (port_rd || port_wr)
      old_nxt = sync2_r[`CHG_HI:`CHG_LO];                         // RULE12 RULE14
    // set beats software clear while mismatch persists
    if (any_mismatch)
      flag_nxt = 1'b1;                                            // RULE13
  end

  //////////////////////////////////////////////////////////////////////////////
  // register update
  always @(posedge aclk) begin
    if (!aresetn) begin
      latch_r    <= `RST_LATCH;
      dir_r      <= `RST_DIRECTION;
      pull_cfg_r <= `RST_PULLUP_CONFIG;                           // RULE8
      flag_r     <= 1'b0;
      // track pins during reset so no false change shows on release
      old_r      <= sync2_r[`CHG_HI:`CHG_LO];
    end else begin
      latch_r    <= latch_nxt;
      dir_r      <= dir_nxt;
      pull_cfg_r <= pull_cfg_nxt;
      flag_r     <= flag_nxt;
      old_r      <= old_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // write channel: address and data are held until both have arrived
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      aw_addr_r <= {ADDR_W{1'b0}};
      w_full_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else begin
      if (aw_hs) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_full_r <= 1'b0;
      end
      if (w_hs) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_full_r <= 1'b0;
      end
    end
  end

  // write response: one answer per write, whether its strobe commits it or not
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= resp_for(wsel);
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data selection; unmapped offsets read as zero
  always @* begin
    rd_word_nxt = 32'h0000_0000;
    case (rsel)
      SEL_PORT:  rd_word_nxt[WIDTH-1:0] = sync2_r;                 // RULE4
      SEL_PULL:  rd_word_nxt[WIDTH-1:0] = pull_cfg_r;
      SEL_DIR:   rd_word_nxt[WIDTH-1:0] = dir_r;
      SEL_INT:   rd_word_nxt[`CHANGE_FLAG_BIT] = flag_r;           // RULE18
      SEL_BITOP: rd_word_nxt[WIDTH-1:0] = latch_r;
      default:   rd_word_nxt = 32'h0000_0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= resp_for(rsel);
      s_axi_rdata  <= rd_word_nxt;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// *** core/gpio_change_port_defines.vh ***
// constants for the bidirectional port with change detection
`ifndef GPIO_CHANGE_PORT_DEFINES_VH
`define GPIO_CHANGE_PORT_DEFINES_VH

// register indices; byte address is four times the index
`define IDX_PORT_DATA      10'h006
`define IDX_PULLUP_CONFIG  10'h081
`define IDX_DIRECTION      10'h086
`define IDX_INT_CONTROL    10'h00c
`define IDX_BIT_OP         10'h00d

// field positions
`define PULLUP_DIS_N_BIT   7
`define CHANGE_FLAG_BIT    0
`define CHG_HI             7
`define CHG_LO             4
`define BITOP_SET_LO       0
`define BITOP_CLR_LO       8

// reset values
`define RST_PULLUP_CONFIG  8'hff
`define RST_DIRECTION      8'hff
`define RST_LATCH          8'h00

// bus answers
`define RESP_OKAY          2'b00
`define RESP_SLVERR        2'b10

`endif

// *** tb/gpio_change_port_monitor.sv ***
// checker for the bidirectional port with change detection
`timescale 1ns/1ps
module gpio_change_port_monitor (
  input logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
  input logic        s_axi_wready, s_axi_bvalid, s_axi_arvalid, s_axi_arready,
  input logic        s_axi_rvalid, s_axi_rready, change_int_flag, wake_req,
  input logic [31:0] s_axi_rdata,
  input logic [7:0]  pin_in, pin_out, pin_oe, pullup_en
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // bus valids all low; a held write can still commit here and move the compare reference
  wire quiet = !(s_axi_arvalid | s_axi_awvalid | s_axi_wvalid | s_axi_bvalid | s_axi_rvalid);
  a_undriven_low: assert property ((pin_out & ~pin_oe) == 8'h00)
    else $error("undriven pin carries data");
  a_pullup_output: assert property ((pullup_en & pin_oe) == 8'h00)
    else $error("pull-up on a driven pin");
  a_reset_state: assert property ($rose(aresetn) |-> !change_int_flag && (pin_oe | pullup_en) == 8'h00)
    else $error("state after reset");
  a_wake_follows: assert property (wake_req == change_int_flag)
    else $error("wake differs from flag");
  a_flag_sticky: assert property ($fell(change_int_flag) |-> $rose(s_axi_bvalid))
    else $error("flag dropped without a write");
  a_change_sets: assert property ($changed(pin_in[7:4]) && pin_oe[7:4] == 4'h0 && quiet ##1
    (quiet && $stable(pin_in))[*2] |=> change_int_flag) else $error("change not flagged");
  a_masked_quiet: assert property ((!change_int_flag && quiet &&
    $stable(pin_in[7:4] | pin_oe[7:4]))[*4] |=> !change_int_flag) else $error("spurious flag");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
  c_flag_set: cover property ($rose(change_int_flag));
  c_flag_clr: cover property ($fell(change_int_flag));
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind gpio_change_port gpio_change_port_monitor mon_u (.*);

// *** tb/keypad_model.sv ***
// keypad on the port pins: a driven pin shows its output, else a key pulls low, else pull-up or a floating wire
`timescale 1ns/1ps
module keypad_model (
  input  logic       aclk,
  input  logic [7:0] pin_out, pin_oe, pullup_en, key_down,
  output logic [7:0] pin_in
);
  // a floating pin wanders every cycle, so stale levels are never read back
  logic flt_r = 1'b0;
  always @(posedge aclk) flt_r <= ~flt_r;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : key_down[i] ? 1'b0 :
                  pullup_en[i] ? 1'b1 : flt_r;
    end
  end
endmodule

// *** tb/test_bidir_port_change_interrupt.sv ***
// bench for the port with change detection: bus tasks and pin scenarios
`timescale 1ns/1ps
`include "gpio_change_port_defines.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module test_bidir_port_change_interrupt;
  localparam logic [11:0] a_dat = {`IDX_PORT_DATA, 2'b00}, a_cfg = {`IDX_PULLUP_CONFIG, 2'b00};
  localparam logic [11:0] a_dir = {`IDX_DIRECTION, 2'b00}, a_int = {`IDX_INT_CONTROL, 2'b00};
  localparam logic [11:0] a_bit = {`IDX_BIT_OP, 2'b00};
  localparam logic [1:0]  ok = `RESP_OKAY, err = `RESP_SLVERR;
  logic        aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0;
  logic        s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic [2:0]  s_axi_awprot = '0, s_axi_arprot = '0;
  logic [7:0]  key_down = '0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         change_int_flag, wake_req;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [7:0]   pin_in, pin_out, pin_oe, pullup_en;
  int          n_errors = 0, total_checks = 0;
  gpio_change_port dut_u (.*);
  keypad_model pad_u (.*);
  initial forever #12.5 aclk = ~aclk;
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    s_axi_bready <= 1'b0;
    if (s_axi_bvalid !== 1'b1) begin n_errors++; summarize(); end
    `CHK(s_axi_bresp, er)
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    s_axi_rready <= 1'b0;
    if (s_axi_rvalid !== 1'b1) begin n_errors++; summarize(); end
    `CHK(s_axi_rdata, {24'h0, e})
    `CHK(s_axi_rresp, er)
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(a_cfg, 8'hff, ok);
    rd(a_dir, 8'hff, ok);
    `CHK(pullup_en | pin_oe, 8'h00)
    rd(12'h100, 8'h00, err);
    wr(12'h100, 8'h12, err);
    $display("test reset done");
    wr(a_cfg, 8'h7f, ok);
    `CHK(pullup_en, 8'hff)
    wr(a_dat, 8'ha5, ok);
    wr(a_dir, 8'hf0, ok);
    `CHK({pin_oe, pin_out, pullup_en}, 24'h0f05f0)
    repeat (3) @(posedge aclk);
    rd(a_dat, 8'hf5, ok);
    $display("test drive done");
    // bit-op store of pin levels: the pulled-up input 6 overwrites its zero latch bit
    key_down <= 8'h10;
    repeat (3) @(posedge aclk);
    wr(a_bit, 8'h02, ok);
    key_down <= 8'h00;
    rd(a_bit, 8'he7, ok);
    wr(a_dir, 8'h00, ok);
    `CHK({pin_out, pullup_en}, 16'he700)
    $display("test modify write done");
    wr(a_dir, 8'hff, ok);
    repeat (3) @(posedge aclk);
    rd(a_dat, 8'hff, ok);
    wr(a_int, 8'h00, ok);
    rd(a_int, 8'h00, ok);
    key_down <= 8'h02;
    repeat (4) @(posedge aclk);
    `CHK(change_int_flag, 1'b0)
    key_down <= 8'h42;
    repeat (3) @(posedge aclk);
    `CHK(change_int_flag, 1'b0)
    @(posedge aclk);
    `CHK({change_int_flag, wake_req}, 2'b11)
    wr(a_int, 8'h00, ok);
    rd(a_int, 8'h01, ok);
    rd(a_dat, 8'hbd, ok);
    wr(a_int, 8'h00, ok);
    rd(a_int, 8'h00, ok);
    wr(a_dir, 8'hef, ok);
    repeat (4) @(posedge aclk);
    `CHK({change_int_flag, pin_in}, 9'h0ad)
    // releasing the key mismatches; a port write must end that
    key_down <= 8'h00;
    repeat (4) @(posedge aclk);
    wr(a_dat, 8'he7, ok);
    wr(a_int, 8'h00, ok);
    rd(a_int, 8'h00, ok);
    $display("test change done");
    summarize();
  end
endmodule
